// >>> design/edge_meter.sv
`timescale 1ns/1ps
module edge_meter (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [7:0] units_i,
  input wire logic pix_clk_i,
  output logic [7:0] count_o,
  output logic busy_o,
  output logic done_o
);
  typedef struct packed {
    logic [7:0] units;
    logic [7:0] tick;
    logic [7:0] count;
    logic busy;
    logic done;
    logic pix_prev;
  } meter_t;
  meter_t s_q, s_d;
  localparam logic [7:0] TICK_LAST = 8'(pin_cfg_pkg::OSC_CYCLES - 1);

  always_comb begin
    s_d = s_q;
    s_d.done = 1'b0;
    s_d.pix_prev = pix_clk_i;
    if (start_i) begin
      s_d.units = units_i;
      s_d.tick = 8'h00;
      s_d.count = 8'h00;
      s_d.busy = (units_i != 8'h00);
      s_d.done = (units_i == 8'h00);
    end else if (s_q.busy) begin
      // Rising edges of the sampled pixel clock; saturate instead of wrap
      if (pix_clk_i && !s_q.pix_prev && s_q.count != 8'hFF) begin
        s_d.count = s_q.count + 8'h01;
      end
      if (s_q.tick == TICK_LAST) begin
        s_d.tick = 8'h00;
        s_d.units = s_q.units - 8'h01;
        if (s_q.units == 8'h01) begin
          s_d.busy = 1'b0;
          s_d.done = 1'b1;
        end
      end else begin
        s_d.tick = s_q.tick + 8'h01;
      end
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign count_o = s_q.count;
  assign busy_o = s_q.busy;
  assign done_o = s_q.done;

  a_count_saturates: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (count_o == 8'hFF && !start_i) |=> count_o == 8'hFF)
    else $error("edge count left saturation");
  a_start_clears: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    start_i |=> count_o == 8'h00)
    else $error("start did not clear count");
  // Done is registered: it shows at the third edge after the start
  a_one_unit_len: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (start_i && units_i == 8'h01) ##1 (!start_i)[*3] |-> done_o)
    else $error("one unit interval wrong length");
endmodule : edge_meter

// >>> design/pin_cfg_pkg.sv
package pin_cfg_pkg;
  // Register byte addresses (printed offsets are not all multiples of four)
  localparam logic [7:0] PIN_CFG_IDX = 8'h1A;
  localparam logic [7:0] EDGE_CNT_IDX = 8'h1B;
  localparam logic [7:0] LINK_STS_IDX = 8'h1C;
  localparam logic [7:0] IRQ_STS_IDX = 8'h20;
  localparam logic [7:0] IRQ_MASK_IDX = 8'h21;
  localparam logic [9:0] PIN_CFG_ADDR = {PIN_CFG_IDX, 2'b00};
  localparam logic [9:0] EDGE_CNT_ADDR = {EDGE_CNT_IDX, 2'b00};
  localparam logic [9:0] LINK_STS_ADDR = {LINK_STS_IDX, 2'b00};
  localparam logic [9:0] IRQ_STS_ADDR = {IRQ_STS_IDX, 2'b00};
  localparam logic [9:0] IRQ_MASK_ADDR = {IRQ_MASK_IDX, 2'b00};
  // Pin configuration field positions
  localparam int GLB_OUT_BIT = 7;
  localparam int GLB_DIR_BIT = 5;
  localparam int GLB_EN_BIT = 4;
  localparam int P9_OUT_BIT = 3;
  localparam int P9_DIR_BIT = 1;
  localparam int P9_EN_BIT = 0;
  localparam logic [7:0] PIN_CFG_WMASK = 8'hBB;
  localparam logic [7:0] PIN_CFG_RST = 8'h00;
  localparam logic [7:0] EDGE_CNT_RST = 8'h00;
  // Status field positions
  localparam int TX_DUAL_BIT = 5;
  localparam int RX_DUAL_BIT = 4;
  localparam int AUD_LOCK_BIT = 3;
  localparam int SIG_DET_BIT = 1;
  localparam int LOCK_BIT = 0;
  // Interrupt events: 0 measurement done, 1 lock change, 2 detect change
  localparam int IRQ_W = 3;
  localparam logic [IRQ_W-1:0] IRQ_RST = 3'h0;
  // Oscillator period per interval unit and its cycle count
  localparam int OSC_PERIOD_NS = 50;
  localparam int CLK_PERIOD_NS = 25;
  localparam int OSC_CYCLES = (OSC_PERIOD_NS + CLK_PERIOD_NS - 1)
                              / CLK_PERIOD_NS;
  // Pair decode {dir,en}
  localparam logic [1:0] MODE_FUNC = 2'b00;
  localparam logic [1:0] MODE_TRI = 2'b10;
  localparam logic [1:0] MODE_OUT = 2'b01;
  localparam logic [1:0] MODE_IN = 2'b11;
endpackage : pin_cfg_pkg

// >>> design/pin_cfg_regs.sv
// The APB register port was chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - Global output drives non-individual pins when output
// - Global pair: func, tristate, force out, in
// - Per-pin settings override global settings
// - Pin9 drives stored level in output mode when pin9_remote_i is low
// - Pin9 pair: func, tristate, gp out, in
// - Writing counter starts edge measurement
// - Counter read returns last counted edges
// - Transmit dual-link flag mirrors outgoing mode
// - Receive dual-link flag mirrors incoming mode
// - Audio lock bit shows audio PLL lock
// - Signal-detect bit shows serial input present
// - Lock bit shows recovery PLL lock
// - Dual-link lock needs both channels locked
module pin_cfg_regs #(
  parameter int NPINS = 4
) (
  input wire logic core_clk_i,
  input wire logic rst_i,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [3:0] pstrb_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  input wire logic pix_clk_i,
  input wire logic [NPINS-1:0] pin_gp_sel_i,
  input wire logic [NPINS-1:0] func_out_i,
  output logic [NPINS-1:0] pin_out_o,
  output logic [NPINS-1:0] pin_oe_o,
  input wire logic pin9_func_out_i,
  input wire logic pin9_remote_i,
  input wire logic pin9_remote_level_i,
  output logic pin9_out_o,
  output logic pin9_oe_o,
  input wire logic tx_dual_i,
  input wire logic rx_dual_i,
  input wire logic audio_lock_i,
  input wire logic sig_detect_i,
  input wire logic [1:0] chan_lock_i,
  output logic irq_o
);
  typedef struct packed {
    logic [7:0] pin_cfg;
    logic [7:0] status;
    logic [pin_cfg_pkg::IRQ_W-1:0] irq_sts;
    logic [pin_cfg_pkg::IRQ_W-1:0] irq_mask;
    logic [31:0] rdata;
  } regs_t;
  regs_t r_q, r_d;

  logic setup;
  logic access;
  logic wr_en;
  logic rd_en;
  logic hit;
  logic [9:0] addr;
  logic [7:0] cnt;
  logic busy;
  logic done;
  logic start;
  logic lock_now;
  logic [7:0] sts_now;
  logic [pin_cfg_pkg::IRQ_W-1:0] events;
  logic [1:0] glb_mode;
  logic [1:0] p9_mode;

  // =====================================================
  // APB decode: zero-wait, unmapped addresses answer SLVERR
  assign addr = {paddr_i[9:2], 2'b00};
  assign setup = psel_i && !penable_i;
  assign access = psel_i && penable_i;
  assign hit = (paddr_i[1:0] == 2'b00) &&
               (addr == pin_cfg_pkg::PIN_CFG_ADDR ||
                addr == pin_cfg_pkg::EDGE_CNT_ADDR ||
                addr == pin_cfg_pkg::LINK_STS_ADDR ||
                addr == pin_cfg_pkg::IRQ_STS_ADDR ||
                addr == pin_cfg_pkg::IRQ_MASK_ADDR) &&
               (paddr_i[11:10] == 2'b00);
  assign wr_en = access && pwrite_i && hit && pstrb_i[0];
  assign rd_en = setup && !pwrite_i;
  assign pready_o = 1'b1;
  assign pslverr_o = access && !hit;
  assign start = wr_en && addr == pin_cfg_pkg::EDGE_CNT_ADDR;

  // =====================================================
  // Pixel clock measurement
  edge_meter u_meter (
    .core_clk_i(core_clk_i),
    .rst_i(rst_i),
    .start_i(start),
    .units_i(pwdata_i[7:0]),
    .pix_clk_i(pix_clk_i),
    .count_o(cnt),
    .busy_o(busy),
    .done_o(done)
  );

  // =====================================================
  // Link status
  // Lock in dual mode needs both channels, otherwise channel 0 alone
  assign lock_now = rx_dual_i ? &chan_lock_i : chan_lock_i[0];
  always_comb begin
    sts_now = 8'h00;
    sts_now[pin_cfg_pkg::TX_DUAL_BIT] = tx_dual_i;
    sts_now[pin_cfg_pkg::RX_DUAL_BIT] = rx_dual_i;
    sts_now[pin_cfg_pkg::AUD_LOCK_BIT] = audio_lock_i;
    sts_now[pin_cfg_pkg::SIG_DET_BIT] = sig_detect_i;
    sts_now[pin_cfg_pkg::LOCK_BIT] = lock_now;
  end
  assign events = {
    sts_now[pin_cfg_pkg::SIG_DET_BIT] != r_q.status[pin_cfg_pkg::SIG_DET_BIT],
    sts_now[pin_cfg_pkg::LOCK_BIT] != r_q.status[pin_cfg_pkg::LOCK_BIT],
    done
  };

  // =====================================================
  // Register state
  always_comb begin
    r_d = r_q;
    r_d.status = sts_now;
    if (wr_en && addr == pin_cfg_pkg::PIN_CFG_ADDR) begin
      r_d.pin_cfg = pwdata_i[7:0] & pin_cfg_pkg::PIN_CFG_WMASK;
    end
    if (wr_en && addr == pin_cfg_pkg::IRQ_MASK_ADDR) begin
      r_d.irq_mask = pwdata_i[pin_cfg_pkg::IRQ_W-1:0];
    end
    if (wr_en && addr == pin_cfg_pkg::IRQ_STS_ADDR) begin
      r_d.irq_sts = r_q.irq_sts & ~pwdata_i[pin_cfg_pkg::IRQ_W-1:0];
    end
    // A new event wins over a simultaneous clear
    r_d.irq_sts = r_d.irq_sts | events;
    if (rd_en) begin
      r_d.rdata = 32'h0000_0000;
      case (addr)
        pin_cfg_pkg::PIN_CFG_ADDR: r_d.rdata[7:0] = r_q.pin_cfg;
        pin_cfg_pkg::EDGE_CNT_ADDR: r_d.rdata[7:0] = cnt;
        pin_cfg_pkg::LINK_STS_ADDR: r_d.rdata[7:0] = r_q.status;
        pin_cfg_pkg::IRQ_STS_ADDR: r_d.rdata[2:0] = r_q.irq_sts;
        pin_cfg_pkg::IRQ_MASK_ADDR: r_d.rdata[2:0] = r_q.irq_mask;
        default: r_d.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      r_q.pin_cfg <= pin_cfg_pkg::PIN_CFG_RST;
      r_q.status <= 8'h00;
      r_q.irq_sts <= pin_cfg_pkg::IRQ_RST;
      r_q.irq_mask <= pin_cfg_pkg::IRQ_RST;
      r_q.rdata <= 32'h0000_0000;
    end else begin
      r_q <= r_d;
    end
  end

  assign prdata_o = r_q.rdata;
  assign irq_o = |(r_q.irq_sts & r_q.irq_mask);

  // =====================================================
  // Pin drive
  assign glb_mode = {r_q.pin_cfg[pin_cfg_pkg::GLB_DIR_BIT],
                     r_q.pin_cfg[pin_cfg_pkg::GLB_EN_BIT]};
  assign p9_mode = {r_q.pin_cfg[pin_cfg_pkg::P9_DIR_BIT],
                    r_q.pin_cfg[pin_cfg_pkg::P9_EN_BIT]};

  // Pins picked individually keep their own drive; the global pair
  // reaches only the rest, so per-pin settings always take precedence
  for (genvar i = 0; i < NPINS; i++) begin : g_pin
    always_comb begin
      pin_out_o[i] = func_out_i[i];
      pin_oe_o[i] = 1'b1;
      if (!pin_gp_sel_i[i]) begin
        case (glb_mode)
          pin_cfg_pkg::MODE_FUNC: begin
            pin_out_o[i] = func_out_i[i];
            pin_oe_o[i] = 1'b1;
          end
          pin_cfg_pkg::MODE_TRI: begin
            pin_out_o[i] = 1'b0;
            pin_oe_o[i] = 1'b0;
          end
          pin_cfg_pkg::MODE_OUT: begin
            pin_out_o[i] = r_q.pin_cfg[pin_cfg_pkg::GLB_OUT_BIT];
            pin_oe_o[i] = 1'b1;
          end
          default: begin
            pin_out_o[i] = 1'b0;
            pin_oe_o[i] = 1'b0;
          end
        endcase
      end
    end
  end

  always_comb begin
    pin9_out_o = pin9_func_out_i;
    pin9_oe_o = 1'b1;
    if (pin9_remote_i) begin
      pin9_out_o = pin9_remote_level_i;
      pin9_oe_o = 1'b1;
    end else begin
      case (p9_mode)
        pin_cfg_pkg::MODE_FUNC: begin
          pin9_out_o = pin9_func_out_i;
          pin9_oe_o = 1'b1;
        end
        pin_cfg_pkg::MODE_TRI: begin
          pin9_out_o = 1'b0;
          pin9_oe_o = 1'b0;
        end
        pin_cfg_pkg::MODE_OUT: begin
          pin9_out_o = r_q.pin_cfg[pin_cfg_pkg::P9_OUT_BIT];
          pin9_oe_o = 1'b1;
        end
        default: begin
          pin9_out_o = 1'b0;
          pin9_oe_o = 1'b0;
        end
      endcase
    end
  end

  // =====================================================
  // Checks
  a_glb_out_drive: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (glb_mode == pin_cfg_pkg::MODE_OUT && !pin_gp_sel_i[0]) |->
    (pin_oe_o[0] && pin_out_o[0] == r_q.pin_cfg[pin_cfg_pkg::GLB_OUT_BIT]))
    else $error("global output level not driven");
  a_glb_last_pin: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (glb_mode == pin_cfg_pkg::MODE_OUT && !pin_gp_sel_i[NPINS-1]) |->
    (pin_oe_o[NPINS-1] &&
     pin_out_o[NPINS-1] == r_q.pin_cfg[pin_cfg_pkg::GLB_OUT_BIT]))
    else $error("global level missing on last pin");
  a_glb_tristate: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (glb_mode[1] && !pin_gp_sel_i[0]) |-> !pin_oe_o[0])
    else $error("global input or tristate still driving");
  a_glb_in_quiet: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (glb_mode[1] && !pin_gp_sel_i[0]) |-> !pin_out_o[0])
    else $error("global input or tristate pin not low");
  a_glb_func_mode: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (glb_mode == pin_cfg_pkg::MODE_FUNC && !pin_gp_sel_i[0]) |->
    (pin_oe_o[0] && pin_out_o[0] == func_out_i[0]))
    else $error("global functional mode not passed through");
  a_pin_override: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    pin_gp_sel_i[0] |-> (pin_oe_o[0] && pin_out_o[0] == func_out_i[0]))
    else $error("global setting overrode pin");
  a_p9_out_drive: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (p9_mode == pin_cfg_pkg::MODE_OUT && !pin9_remote_i) |->
    (pin9_oe_o && pin9_out_o == r_q.pin_cfg[pin_cfg_pkg::P9_OUT_BIT]))
    else $error("pin9 level not driven");
  a_p9_remote: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    pin9_remote_i |->
    (pin9_oe_o && pin9_out_o == pin9_remote_level_i))
    else $error("pin9 ignores remote level");
  a_p9_input: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (p9_mode[1] && !pin9_remote_i) |-> !pin9_oe_o)
    else $error("pin9 drives in input mode");
  a_p9_func_mode: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (p9_mode == pin_cfg_pkg::MODE_FUNC && !pin9_remote_i) |->
    (pin9_oe_o && pin9_out_o == pin9_func_out_i))
    else $error("pin9 functional level not passed through");
  a_p9_tristate: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (p9_mode == pin_cfg_pkg::MODE_TRI && !pin9_remote_i) |->
    (!pin9_oe_o && !pin9_out_o))
    else $error("pin9 drives in tristate mode");
  a_start_runs: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    start |=> (busy || done))
    else $error("write did not start a measurement");
  a_done_irq: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    done |=> r_q.irq_sts[0])
    else $error("measurement end not flagged");
  a_count_read: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (rd_en && addr == pin_cfg_pkg::EDGE_CNT_ADDR) |=>
    prdata_o == {24'h000000, $past(cnt)})
    else $error("counter read wrong");
  // Status checks skip the reset edge, where the inputs may already move
  a_status_follow: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    !rst_i |=> r_q.status[5:4] == $past({tx_dual_i, rx_dual_i}))
    else $error("dual flags stale");
  a_rx_dual_flag: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    !rst_i |=>
    r_q.status[pin_cfg_pkg::RX_DUAL_BIT] == $past(rx_dual_i))
    else $error("receive dual flag stale");
  a_status_audio: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    !rst_i |=> r_q.status[3:1] == {$past(audio_lock_i), 1'b0,
    $past(sig_detect_i)})
    else $error("audio or detect flag wrong");
  a_detect_flag: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    !rst_i |=>
    r_q.status[pin_cfg_pkg::SIG_DET_BIT] == $past(sig_detect_i))
    else $error("signal detect flag stale");
  a_lock_single: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (!rst_i && !rx_dual_i) |=> r_q.status[0] == $past(chan_lock_i[0]))
    else $error("lock bit wrong");
  a_dual_lock: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (rx_dual_i && !chan_lock_i[1]) |=> !r_q.status[0])
    else $error("dual lock with one channel");
  a_dual_lock_both: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (!rst_i && rx_dual_i && &chan_lock_i) |=> r_q.status[0])
    else $error("dual lock missing with both channels");
  a_reserved_zero: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (r_q.pin_cfg[6] == 1'b0) && (r_q.pin_cfg[2] == 1'b0))
    else $error("reserved bit set");
  a_status_rsvd: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    r_q.status[7:6] == 2'b00 && !r_q.status[2])
    else $error("reserved status bit set");
  a_cfg_write: assert property (
    @(posedge core_clk_i) disable iff (rst_i)
    (wr_en && addr == pin_cfg_pkg::PIN_CFG_ADDR) |=>
    r_q.pin_cfg == ($past(pwdata_i[7:0]) & pin_cfg_pkg::PIN_CFG_WMASK))
    else $error("config write not stored");
endmodule : pin_cfg_regs

// >>> test/test_pin_cfg_freq_count_status_regs.sv
`timescale 1ns/1ps
`define CHK(n, e, g) begin num_checks++; if ((g) !== (e)) begin num_errors++; \
  $display("mismatch %s exp %h got %h", n, e, g); end end

module test_pin_cfg_freq_count_status_regs;
  logic core_clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [11:0] paddr_i = 12'h000;
  logic [31:0] pwdata_i = 32'h0;
  logic [3:0] pstrb_i = 4'hF;
  logic [31:0] prdata_o;
  logic pready_o;
  logic pslverr_o;
  logic pix_clk_i = 1'b0;
  logic [3:0] pin_gp_sel_i = 4'h0;
  logic [3:0] func_out_i = 4'h0;
  logic [3:0] pin_out_o;
  logic [3:0] pin_oe_o;
  logic pin9_func_out_i = 1'b0;
  logic pin9_remote_i = 1'b0;
  logic pin9_remote_level_i = 1'b0;
  logic pin9_out_o;
  logic pin9_oe_o;
  logic tx_dual_i = 1'b0;
  logic rx_dual_i = 1'b0;
  logic audio_lock_i = 1'b0;
  logic sig_detect_i = 1'b0;
  logic [1:0] chan_lock_i = 2'h0;
  logic irq_o;
  int num_errors = 0;
  int num_checks = 0;
  int cyc = 0;
  int pix_per = 2;
  int pdiv = 0;
  bit pix_run = 1'b0;
  logic [31:0] r;
  logic e;
  logic [7:0] v, s, ex;
  logic [3:0] eo, eout;
  logic o9, e9;

  pin_cfg_regs #(.NPINS(4)) u_pin_cfg_regs (.core_clk_i(core_clk_i),
    .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i),
    .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .pstrb_i(pstrb_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .pix_clk_i(pix_clk_i),
    .pin_gp_sel_i(pin_gp_sel_i), .func_out_i(func_out_i),
    .pin_out_o(pin_out_o), .pin_oe_o(pin_oe_o),
    .pin9_func_out_i(pin9_func_out_i), .pin9_remote_i(pin9_remote_i),
    .pin9_remote_level_i(pin9_remote_level_i), .pin9_out_o(pin9_out_o),
    .pin9_oe_o(pin9_oe_o), .tx_dual_i(tx_dual_i), .rx_dual_i(rx_dual_i),
    .audio_lock_i(audio_lock_i), .sig_detect_i(sig_detect_i),
    .chan_lock_i(chan_lock_i), .irq_o(irq_o));

  // ==========================================
  // Clock, pixel clock and hang guard
  always #12.5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      num_errors++;
      stop_test();
    end
    if (pix_run) begin
      if (pdiv >= pix_per - 1) begin
        pdiv <= 0;
        pix_clk_i <= ~pix_clk_i;
      end else begin
        pdiv <= pdiv + 1;
      end
    end
  end

  task stop_test;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : stop_test

  // ==========================================
  // Bus access: hold the request until pready is seen high
  task automatic apb(input bit wr, input logic [11:0] a,
                     input logic [31:0] dat, output logic [31:0] rd_o,
                     output logic er);
    @(posedge core_clk_i);
    psel_i <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i <= wr;
    paddr_i <= a;
    pwdata_i <= dat;
    @(posedge core_clk_i);
    penable_i <= 1'b1;
    do @(posedge core_clk_i); while (pready_o !== 1'b1);
    rd_o = prdata_o;
    er = pslverr_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb

  task automatic wr(input logic [9:0] a, input logic [7:0] dat);
    logic [31:0] x;
    logic y;
    apb(1'b1, {2'b00, a}, {24'h0, dat}, x, y);
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [7:0] ex_v,
                    input string nm);
    logic [31:0] x;
    logic y;
    apb(1'b0, {2'b00, a}, 32'h0, x, y);
    `CHK(nm, {24'h0, ex_v}, x)
  endtask : rd

  // Edge model counts rising pixel edges seen at the 2*n edges after
  // the start; an edge needs two samples, so at most n are counted
  task automatic meas(input int n, input int p);
    int cnt;
    int d;
    bit pv;
    cnt = 0;
    pix_per = p;
    pix_run = 1'b1;
    wr(pin_cfg_pkg::EDGE_CNT_ADDR, n[7:0]);
    pv = pix_clk_i;
    for (int k = 0; k < 2 * n; k++) begin
      @(posedge core_clk_i);
      if (pix_clk_i && !pv) cnt++;
      pv = pix_clk_i;
    end
    repeat (4) @(posedge core_clk_i);
    apb(1'b0, {2'b00, pin_cfg_pkg::EDGE_CNT_ADDR}, 32'h0, r, e);
    d = (cnt > 255) ? 255 : cnt;
    `CHK("edge_cnt", 32'(d), r)
    $display("test measure n=%0d done", n);
  endtask : meas

  // ==========================================
  // Main sequence
  initial begin
    void'($urandom(22032));
    repeat (5) @(posedge core_clk_i);
    rst_i <= 1'b0;
    rd(pin_cfg_pkg::PIN_CFG_ADDR, 8'h00, "cfg_rst");
    rd(pin_cfg_pkg::EDGE_CNT_ADDR, 8'h00, "cnt_rst");
    rd(pin_cfg_pkg::LINK_STS_ADDR, 8'h00, "sts_rst");
    $display("test reset done");
    for (int m = 0; m < 16; m++) begin
      v = 8'($urandom);
      v[1:0] = m[1:0];
      v[5:4] = m[3:2];
      pin9_remote_i <= ($urandom % 4 == 0);
      pin_gp_sel_i <= 4'($urandom);
      func_out_i <= 4'($urandom);
      pin9_func_out_i <= 1'($urandom);
      pin9_remote_level_i <= 1'($urandom);
      wr(pin_cfg_pkg::PIN_CFG_ADDR, v);
      @(negedge core_clk_i);
      eout = 4'h0;
      eo = 4'h0;
      if (v[5:4] == 2'b00) {eo, eout} = {4'hF, func_out_i};
      if (v[5:4] == 2'b01) {eo, eout} = {4'hF, {4{v[7]}}};
      {e9, o9} = 2'b00;
      if (v[1:0] == 2'b00) {e9, o9} = {1'b1, pin9_func_out_i};
      if (v[1:0] == 2'b01) {e9, o9} = {1'b1, v[3]};
      if (pin9_remote_i) {e9, o9} = {1'b1, pin9_remote_level_i};
      // Individually selected pins keep their own functional drive
      eo = eo | pin_gp_sel_i;
      eout = (eout & ~pin_gp_sel_i) | (func_out_i & pin_gp_sel_i);
      ex[3:0] = func_out_i & pin_gp_sel_i;
      `CHK("pin_oe", eo, pin_oe_o)
      `CHK("pin_out", eout, pin_out_o)
      `CHK("pin_own", ex[3:0], pin_out_o & pin_gp_sel_i)
      `CHK("pin9_oe", e9, pin9_oe_o)
      `CHK("pin9_out", o9, pin9_out_o)
      rd(pin_cfg_pkg::PIN_CFG_ADDR, v & 8'hBB, "pin_cfg");
    end
    $display("test pin config done");
    for (int i = 0; i < 8; i++) begin
      s = (i == 0) ? 8'h12 : 8'($urandom);
      {chan_lock_i, sig_detect_i, audio_lock_i, rx_dual_i, tx_dual_i}
        <= s[5:0];
      @(posedge core_clk_i);
      ex = {2'b00, s[0], s[1], s[2], 1'b0, s[3], s[1] ? &s[5:4] : s[4]};
      rd(pin_cfg_pkg::LINK_STS_ADDR, ex, "link_sts");
    end
    wr(pin_cfg_pkg::LINK_STS_ADDR, 8'hFF);
    rd(pin_cfg_pkg::LINK_STS_ADDR, ex, "sts_ro");
    apb(1'b0, 12'h074, 32'h0, r, e);
    `CHK("unmapped", 33'h100000000, {e, r})
    $display("test status done");
    rx_dual_i <= 1'b0;
    wr(pin_cfg_pkg::IRQ_MASK_ADDR, 8'h00);
    wr(pin_cfg_pkg::IRQ_STS_ADDR, 8'h07);
    rd(pin_cfg_pkg::IRQ_STS_ADDR, 8'h00, "irq_clr");
    sig_detect_i <= ~sig_detect_i;
    repeat (3) @(posedge core_clk_i);
    rd(pin_cfg_pkg::IRQ_STS_ADDR, 8'h04, "irq_det");
    `CHK("irq_masked", 1'b0, irq_o)
    wr(pin_cfg_pkg::IRQ_MASK_ADDR, 8'h04);
    @(negedge core_clk_i);
    `CHK("irq_on", 1'b1, irq_o)
    wr(pin_cfg_pkg::IRQ_STS_ADDR, 8'h04);
    @(negedge core_clk_i);
    `CHK("irq_off", 1'b0, irq_o)
    chan_lock_i[0] <= ~chan_lock_i[0];
    repeat (3) @(posedge core_clk_i);
    rd(pin_cfg_pkg::IRQ_STS_ADDR, 8'h02, "irq_lock");
    wr(pin_cfg_pkg::IRQ_STS_ADDR, 8'h07);
    wr(pin_cfg_pkg::IRQ_MASK_ADDR, 8'h01);
    meas(3, 2);
    `CHK("irq_done", 1'b1, irq_o)
    wr(pin_cfg_pkg::IRQ_STS_ADDR, 8'h01);
    $display("test interrupt done");
    meas(0, 2);
    meas(1, 3);
    for (int i = 0; i < 4; i++) meas($urandom_range(1, 60), $urandom_range(2, 5));
    // Toggling every cycle gives an edge per unit, so the count tops out
    meas(255, 1);
    stop_test();
  end
endmodule : test_pin_cfg_freq_count_status_regs
